// file: core/analog_sensor_defines.vh
// register offsets, field positions, codes and defaults of the sensor object
// assumes inclusion by bare name from the design files under core/
`ifndef ANALOG_SENSOR_DEFINES_VH
`define ANALOG_SENSOR_DEFINES_VH

// wishbone word offsets, decoded from address bits 5:2
`define OFS_SVC_CMD     4'h0
`define OFS_SVC_DATA    4'h1
`define OFS_SVC_RESP    4'h2
`define OFS_SVC_RDATA   4'h3
`define OFS_CONN_CMD    4'h4
`define OFS_CONN_STAT   4'h5
`define OFS_OBJ_STAT    4'h6

// service command register fields
`define CMD_CODE_LSB    0
`define CMD_ATTR_LSB    8
`define CMD_TGT_BIT     16
// connection command register fields
`define CONN_OPEN_BIT   0
`define CONN_CLOSE_BIT  1
`define CONN_TYPE_LSB   8

// service codes
`define SVC_GET         8'h0e
`define SVC_SET         8'h10
`define SVC_ZERO        8'h4b

// attribute ids
`define ATT_DTYPE       8'h03
`define ATT_UNITS       8'h04
`define ATT_VALID       8'h05
`define ATT_VALUE       8'h06
`define ATT_STATUS      8'h07
`define ATT_FSCALE      8'h0a
`define ATT_SSTATE      8'h19
`define ATT_SVALUE      8'h1a
`define ATT_OVER        8'h20
`define ATT_UNDER       8'h21
`define ATT_WARN        8'h5e
`define ATT_ALARM       8'h5f
`define ATT_STEXT       8'h60
`define ATT_SUBCL       8'h63

// data type codes and type limits
`define DT_INT          8'hc3
`define DT_REAL         8'hca
`define INT_MAX         32'h00007fff
`define INT_MIN         32'hffff8000
`define REAL_MAX        32'h7f7fffff
`define REAL_MIN        32'hff7fffff

// defaults and fixed values
`define UNITS_COUNTS    16'h1001
`define SUBCLASS_CDG    16'h0003
`define SAFE_ZERO       2'h0
`define SAFE_FULL       2'h1
`define SAFE_HOLD       2'h2
`define SAFE_VALUE      2'h3

// general and additional error codes
`define ERR_NONE        8'h00
`define ERR_NO_SVC      8'h08
`define ERR_BAD_VALUE   8'h09
`define ERR_STATE       8'h0c
`define ERR_RDONLY      8'h0e
`define ERR_NO_ATTR     8'h14
`define ADD_CONN_PATH   8'h10

// object states on objState
`define OST_IDLE        2'h0
`define OST_EXEC        2'h1

`endif

// file: core/analog_value_path.v
// value output stage: live reading while executing, safe behaviour otherwise
// assumes reading already corrected and encoded in the selected data type
`timescale 1ns/100ps
`include "analog_sensor_defines.vh"

module analog_value_path (
    input  wire        sys_clk,
    input  wire        srst,
    input  wire        executing,
    input  wire [1:0]  safeState,
    input  wire [31:0] safeValue,
    input  wire [31:0] fullScale,
    input  wire [31:0] reading,
    output reg  [31:0] value_ff
);
    reg [31:0] nxt_value;

    // hold keeps value_ff, so the last live reading survives the state change
    always @* begin
        nxt_value = value_ff;
        if (executing) begin
            nxt_value = reading;
        end else begin
            case (safeState)
                `SAFE_ZERO:  nxt_value = 32'h00000000;
                `SAFE_FULL:  nxt_value = fullScale;
                `SAFE_HOLD:  nxt_value = value_ff;
                `SAFE_VALUE: nxt_value = safeValue;
                default:     nxt_value = 32'h00000000;
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            value_ff <= 32'h00000000;
        end else begin
            value_ff <= nxt_value;
        end
    end
endmodule

// file: core/analog_sensor_attrs.v
// attribute store and service engine of the atmosphere sensor object instance
// software reaches attributes through a service mailbox and a connection word
// assumes a classic wishbone master and a sensor front end on sys_clk
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "analog_sensor_defines.vh"

// Summary of operation
// - service 4B hex requests zero calibration
// - zero request updates instance 1 offset
// - target is wanted reading, default zero
// - success once started, no state change
// - first connection sets data type
// - data type writable only idle, unconnected; the first connection still writes it in any object state
// - type fixed before connection data moves
// - mismatched connection refused, path code
// - attribute 3 data type, default INT
// - attribute 4 units, default counts
// - attribute 5 always reads valid
// - attribute 6 returns final reading
// - attribute 7 status reads zero
// - attribute 10 full scale, type maximum
// - attributes 25, 26 settable, default zero
// - attribute 32 overrange, type maximum
// - attribute 33 underrange, type minimum
// - attributes 94, 95 read zero
// - attribute 96 status extension, default zero
// - attribute 99 reads subclass 3
// - safe state codes zero/full/hold/value
// - 0E hex gets, 10 hex sets
module analog_sensor_attrs #(
    parameter CONN_W = 4
) (
    input  wire        sys_clk,
    input  wire        srst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_adr_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [1:0]  objState,
    input  wire [31:0] sensorReading,
    input  wire [31:0] offsetIn,
    output reg  [31:0] offsetA_ff,
    output reg         offsetWr_ff,
    output reg         zeroStart_ff,
    output reg  [31:0] zeroTarget_ff,
    output wire [31:0] valueOut,
    output reg  [7:0]  dataType_ff
);
    // wishbone
    reg [31:0] rdData;
    // service mailbox
    reg [31:0] svcData_ff;
    reg        svcDone_ff;
    reg [7:0]  svcErr_ff;
    reg [31:0] svcRdata_ff;
    // attributes
    reg [15:0] units_ff;
    reg [1:0]  safeState_ff;
    reg [31:0] safeValue_ff;
    // connections
    reg [CONN_W-1:0] connCnt_ff;
    reg              connRej_ff;
    reg [7:0]        connErr_ff;
    reg [7:0]        connAdd_ff;

    wire        wrStb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    wire        rdStb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    wire [3:0]  wIdx  = wb_adr_i[5:2];
    wire        isReal = (dataType_ff == `DT_REAL);
    wire [31:0] fullScale = typeMax(isReal);
    wire [31:0] overLim   = typeMax(isReal);
    wire [31:0] underLim  = typeMin(isReal);
    wire        aboveOver;
    wire        belowUnder;
    wire [7:0]  statusExt;
    wire        executing = (objState == `OST_EXEC);

    function [31:0] typeMax;
        input r;
        begin
            typeMax = r ? `REAL_MAX : `INT_MAX;
        end
    endfunction

    // smallest value the selected type can carry
    function [31:0] typeMin;
        input r;
        begin
            typeMin = r ? `REAL_MIN : `INT_MIN;
        end
    endfunction

    // maps int or float bit patterns to an unsigned order key
    function [31:0] orderKey;
        input [31:0] v;
        input        r;
        begin
            if (r) begin
                orderKey = v[31] ? ~v : (v ^ 32'h80000000);
            end else begin
                orderKey = {16'h0000, ~v[15], v[14:0]};
            end
        end
    endfunction

    // byte lane merge of a write into an old word
    function [31:0] laneMerge;
        input [31:0] oldV;
        input [31:0] newV;
        input [3:0]  sel;
        integer i;
        begin
            laneMerge = oldV;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    laneMerge[i*8 +: 8] = newV[i*8 +: 8];
                end
            end
        end
    endfunction

    // attributes that a set service may modify
    function attrSettable;
        input [7:0] at;
        begin
            attrSettable = (at == `ATT_DTYPE) || (at == `ATT_UNITS) ||
                           (at == `ATT_SSTATE) || (at == `ATT_SVALUE);
        end
    endfunction

    // live value sampled from the front end, held or replaced when not executing
    analog_value_path u_value (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .executing (executing),
        .safeState (safeState_ff),
        .safeValue (safeValue_ff),
        .fullScale (fullScale),
        .reading   (sensorReading),
        .value_ff  (valueOut)
    );

    // compare on order keys so that negative ints and floats sort correctly
    wire [31:0] valKey   = orderKey(valueOut, isReal);
    wire [31:0] overKey  = orderKey(overLim, isReal);
    wire [31:0] underKey = orderKey(underLim, isReal);

    assign aboveOver  = valKey > overKey;
    assign belowUnder = valKey < underKey;
    assign statusExt  = {5'h00, belowUnder, aboveOver, aboveOver | belowUnder};

    // service decode
    wire        svcGo   = wrStb & (wIdx == `OFS_SVC_CMD);
    wire [7:0]  svcCode = wb_dat_i[`CMD_CODE_LSB +: 8];
    wire [7:0]  svcAttr = wb_dat_i[`CMD_ATTR_LSB +: 8];
    wire        svcTgt  = wb_dat_i[`CMD_TGT_BIT];
    reg  [7:0]  nxtErr;
    reg  [31:0] nxtRdata;
    reg         attrKnown;

    // get path and attribute presence
    always @* begin
        attrKnown = 1'b1;
        nxtRdata  = 32'h00000000;
        case (svcAttr)
            `ATT_DTYPE:  nxtRdata = {24'h000000, dataType_ff};
            `ATT_UNITS:  nxtRdata = {16'h0000, units_ff};
            `ATT_VALID:  nxtRdata = 32'h00000001;
            `ATT_VALUE:  nxtRdata = valueOut;
            `ATT_STATUS: nxtRdata = 32'h00000000;
            `ATT_FSCALE: nxtRdata = fullScale;
            `ATT_SSTATE: nxtRdata = {30'h00000000, safeState_ff};
            `ATT_SVALUE: nxtRdata = safeValue_ff;
            `ATT_OVER:   nxtRdata = overLim;
            `ATT_UNDER:  nxtRdata = underLim;
            `ATT_WARN:   nxtRdata = 32'h00000000;
            `ATT_ALARM:  nxtRdata = 32'h00000000;
            `ATT_STEXT:  nxtRdata = {24'h000000, statusExt};
            `ATT_SUBCL:  nxtRdata = {16'h0000, `SUBCLASS_CDG};
            default:     attrKnown = 1'b0;
        endcase
    end

    // error decision for the service being launched
    always @* begin
        nxtErr = `ERR_NONE;
        case (svcCode)
            `SVC_GET: begin
                if (!attrKnown) begin
                    nxtErr = `ERR_NO_ATTR;
                end
            end
            `SVC_SET: begin
                if (!attrKnown) begin
                    nxtErr = `ERR_NO_ATTR;
                end else if (!attrSettable(svcAttr)) begin
                    nxtErr = `ERR_RDONLY;
                end else if (svcAttr == `ATT_DTYPE) begin
                    if (connCnt_ff != {CONN_W{1'b0}} || objState != `OST_IDLE) begin
                        nxtErr = `ERR_STATE;
                    end else if (svcData_ff[7:0] != `DT_INT &&
                                 svcData_ff[7:0] != `DT_REAL) begin
                        nxtErr = `ERR_BAD_VALUE;
                    end
                end else if (svcAttr == `ATT_SSTATE) begin
                    if (svcData_ff[31:2] != 30'h00000000) begin
                        nxtErr = `ERR_BAD_VALUE;
                    end
                end
            end
            `SVC_ZERO: nxtErr = `ERR_NONE;
            default:   nxtErr = `ERR_NO_SVC;
        endcase
    end

    wire setOk  = svcGo & (svcCode == `SVC_SET) & (nxtErr == `ERR_NONE);
    wire zeroGo = svcGo & (svcCode == `SVC_ZERO);
    // absent target means zero reading wanted
    wire [31:0] target = svcTgt ? svcData_ff : 32'h00000000;

    // connection decode
    wire       connGo    = wrStb & (wIdx == `OFS_CONN_CMD);
    wire       connOpen  = connGo & wb_dat_i[`CONN_OPEN_BIT];
    wire       connClose = connGo & wb_dat_i[`CONN_CLOSE_BIT] & ~wb_dat_i[`CONN_OPEN_BIT];
    wire [7:0] connType  = wb_dat_i[`CONN_TYPE_LSB +: 8];
    wire       connFirst = (connCnt_ff == {CONN_W{1'b0}});
    wire       connFull  = (connCnt_ff == {CONN_W{1'b1}});
    wire       typeOk    = (connType == `DT_INT) | (connType == `DT_REAL);
    wire       connMis   = ~connFirst & (connType != dataType_ff);

    // attribute and connection state
    always @(posedge sys_clk) begin
        if (srst) begin
            dataType_ff  <= `DT_INT;
            units_ff     <= `UNITS_COUNTS;
            safeState_ff <= `SAFE_ZERO;
            safeValue_ff <= 32'h00000000;
            connCnt_ff   <= {CONN_W{1'b0}};
            connRej_ff   <= 1'b0;
            connErr_ff   <= `ERR_NONE;
            connAdd_ff   <= 8'h00;
        end else begin
            if (setOk) begin
                case (svcAttr)
                    `ATT_DTYPE:  dataType_ff  <= svcData_ff[7:0];
                    `ATT_UNITS:  units_ff     <= svcData_ff[15:0];
                    `ATT_SSTATE: safeState_ff <= svcData_ff[1:0];
                    `ATT_SVALUE: safeValue_ff <= svcData_ff;
                    default:     units_ff     <= units_ff;
                endcase
            end
            if (connOpen) begin
                if (!typeOk || connMis || connFull) begin
                    connRej_ff <= 1'b1;
                    connErr_ff <= connFull ? `ERR_STATE : `ERR_BAD_VALUE;
                    connAdd_ff <= `ADD_CONN_PATH;
                end else begin
                    // type fixed in the same edge that counts the connection
                    if (connFirst) begin
                        dataType_ff <= connType;
                    end
                    connCnt_ff <= connCnt_ff + {{(CONN_W-1){1'b0}}, 1'b1};
                    connRej_ff <= 1'b0;
                    connErr_ff <= `ERR_NONE;
                    connAdd_ff <= 8'h00;
                end
            end else if (connClose && !connFirst) begin
                connCnt_ff <= connCnt_ff - {{(CONN_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // service mailbox and zero calibration
    always @(posedge sys_clk) begin
        if (srst) begin
            svcData_ff    <= 32'h00000000;
            svcDone_ff    <= 1'b0;
            svcErr_ff     <= `ERR_NONE;
            svcRdata_ff   <= 32'h00000000;
            offsetA_ff    <= 32'h00000000;
            offsetWr_ff   <= 1'b0;
            zeroStart_ff  <= 1'b0;
            zeroTarget_ff <= 32'h00000000;
        end else begin
            offsetWr_ff  <= 1'b0;
            zeroStart_ff <= 1'b0;
            if (wrStb && wIdx == `OFS_SVC_DATA) begin
                svcData_ff <= laneMerge(svcData_ff, wb_dat_i, wb_sel_i);
            end
            if (svcGo) begin
                // answer is final in the same edge, no state change follows
                svcDone_ff  <= 1'b1;
                svcErr_ff   <= nxtErr;
                if (svcCode == `SVC_GET && nxtErr == `ERR_NONE) begin
                    svcRdata_ff <= nxtRdata;
                end else begin
                    svcRdata_ff <= 32'h00000000;
                end
            end
            if (zeroGo) begin
                // simple correction: shift offset by the reading error
                offsetA_ff    <= offsetIn + (target - valueOut);
                offsetWr_ff   <= 1'b1;
                zeroStart_ff  <= 1'b1;
                zeroTarget_ff <= target;
            end
        end
    end

    // status words; the connection count may be at most 7 bits wide
    wire [31:0] respWord = {23'h000000, svcErr_ff, svcDone_ff};
    wire [31:0] connWord = {8'h00, connAdd_ff, connErr_ff, connRej_ff,
                            {(7-CONN_W){1'b0}}, connCnt_ff};
    wire [31:0] objWord  = {22'h000000, statusExt, objState};

    // read mux
    always @* begin
        case (wIdx)
            `OFS_SVC_DATA:  rdData = svcData_ff;
            `OFS_SVC_RESP:  rdData = respWord;
            `OFS_SVC_RDATA: rdData = svcRdata_ff;
            `OFS_CONN_STAT: rdData = connWord;
            `OFS_OBJ_STAT:  rdData = objWord;
            default:        rdData = 32'h00000000;
        endcase
    end

    // classic wishbone: one-cycle ack after request, unmapped reads zero
    always @(posedge sys_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wrStb | rdStb;
            if (rdStb) begin
                wb_dat_o <= rdData;
            end
        end
    end
endmodule

// file: tb/sensor_front_model.sv
// sensor front end model: instance-1 offset store and corrected reading
// assumes raw counts from the bench and offset writes from the block
`timescale 1ns/100ps
module sensor_front_model (
    input  wire        sys_clk,
    input  wire        srst,
    input  wire [15:0] raw,
    input  wire [31:0] offsetA,
    input  wire        offsetWr,
    output reg  [31:0] offsetIn,
    output wire [31:0] reading
);
    wire [15:0] sum = raw + offsetIn[15:0];
    // int reading lives sign-extended in the low half
    assign reading = {{16{sum[15]}}, sum};
    always @(posedge sys_clk) begin
        if (srst) begin
            offsetIn <= 32'h0;
        end else if (offsetWr) begin
            offsetIn <= offsetA;
        end
    end
endmodule

// file: tb/analog_sensor_attrs_props.sv
// port assertions of the sensor attribute block
// assumes one clock domain, bound onto analog_sensor_attrs
`timescale 1ns/100ps
`include "analog_sensor_defines.vh"
module analog_sensor_attrs_props #(
    parameter CONN_W = 4
) (
    input wire        sys_clk,
    input wire        srst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire        wb_ack_o,
    input wire [1:0]  objState,
    input wire [31:0] sensorReading,
    input wire        offsetWr_ff,
    input wire        zeroStart_ff,
    input wire [31:0] zeroTarget_ff,
    input wire [31:0] valueOut,
    input wire [7:0]  dataType_ff
);
    wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire zw = tk & wb_we_i & (wb_adr_i[5:2] == 4'h0) & (wb_dat_i[7:0] == `SVC_ZERO);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    property p_ack; tk |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack)
        else $error("request not acked");
    property p_ackPulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ackPulse: assert property (p_ackPulse)
        else $error("ack longer than one cycle");
    property p_ackCause; wb_ack_o |-> $past(wb_cyc_i & wb_stb_i); endproperty
    a_ackCause: assert property (p_ackCause)
        else $error("ack without request");
    property p_zero; zw |=> zeroStart_ff && offsetWr_ff; endproperty
    a_zero: assert property (p_zero)
        else $error("zero request not started");
    property p_zeroOnly; zeroStart_ff |-> $past(zw); endproperty
    a_zeroOnly: assert property (p_zeroOnly)
        else $error("calibration start without request");
    property p_pair; offsetWr_ff |-> zeroStart_ff; endproperty
    a_pair: assert property (p_pair)
        else $error("offset write outside calibration");
    property p_target; zw && !wb_dat_i[`CMD_TGT_BIT] |=> zeroTarget_ff == 32'h0; endproperty
    a_target: assert property (p_target)
        else $error("missing target not zero");
    property p_dtLegal; dataType_ff == `DT_INT || dataType_ff == `DT_REAL; endproperty
    a_dtLegal: assert property (p_dtLegal)
        else $error("illegal data type");
    property p_dtChg; !$stable(dataType_ff) && !$past(srst) |-> $past(tk & wb_we_i); endproperty
    a_dtChg: assert property (p_dtChg)
        else $error("data type changed without write");
    property p_value;
        !$past(srst) && $past(objState) == `OST_EXEC |-> valueOut == $past(sensorReading);
    endproperty
    a_value: assert property (p_value)
        else $error("value not following reading");
endmodule
bind analog_sensor_attrs analog_sensor_attrs_props #(.CONN_W(CONN_W)) props (
    .sys_clk(sys_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .objState(objState), .sensorReading(sensorReading), .offsetWr_ff(offsetWr_ff),
    .zeroStart_ff(zeroStart_ff), .zeroTarget_ff(zeroTarget_ff),
    .valueOut(valueOut), .dataType_ff(dataType_ff));

// file: tb/tb.sv
// self-checking bench of the sensor attribute block
// assumes a wishbone master here and the front end model on the far side
`timescale 1ns/100ps
`include "analog_sensor_defines.vh"
module tb;
    localparam [103:0] ATL = {8'h63, 8'h60, 8'h5f, 8'h5e, 8'h21, 8'h20, 8'h1a,
                              8'h19, 8'h0a, 8'h07, 8'h05, 8'h04, 8'h03};
    reg         sys_clk = 0;
    reg         srst = 1;
    reg         cyc = 0;
    reg         stb = 0;
    reg         we = 0;
    reg  [31:0] adr = 0;
    reg  [31:0] dat = 0;
    reg  [1:0]  objState = 0;
    reg  [15:0] raw = 0;
    reg  [31:0] rdo, rsp, rd, t, v;
    reg  [7:0]  a;
    wire [31:0] rdat, offA, offsetIn, reading, valueOut, zTgt;
    wire        ack, offWr, zStart;
    wire [7:0]  dataType;
    integer     seed = 5723;
    integer     n_errors = 0;
    integer     checked = 0;
    integer     i;
    always #5 sys_clk = ~sys_clk;
    analog_sensor_attrs #(.CONN_W(4)) dut (.sys_clk(sys_clk), .srst(srst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(4'hf),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .objState(objState), .sensorReading(reading), .offsetIn(offsetIn),
        .offsetA_ff(offA), .offsetWr_ff(offWr), .zeroStart_ff(zStart),
        .zeroTarget_ff(zTgt), .valueOut(valueOut), .dataType_ff(dataType));
    sensor_front_model fe (.sys_clk(sys_clk), .srst(srst), .raw(raw),
        .offsetA(offA), .offsetWr(offWr), .offsetIn(offsetIn), .reading(reading));
    function [31:0] sx(input [15:0] x);
        sx = {{16{x[15]}}, x};
    endfunction
    function [31:0] dflt(input [7:0] at);
        case (at)
            `ATT_DTYPE: dflt = {24'h0, `DT_INT};
            `ATT_UNITS: dflt = {16'h0, `UNITS_COUNTS};
            `ATT_VALID: dflt = 32'h1;
            `ATT_FSCALE, `ATT_OVER: dflt = `INT_MAX;
            `ATT_UNDER: dflt = `INT_MIN;
            `ATT_SUBCL: dflt = {16'h0, `SUBCLASS_CDG};
            default: dflt = 32'h0;
        endcase
    endfunction
    function [31:0] sexp(input [1:0] s);
        case (s)
            2'h0: sexp = 32'h0;
            2'h1: sexp = `INT_MAX;
            2'h2: sexp = t;
            default: sexp = v;
        endcase
    endfunction
    task end_sim;
        begin
            if (n_errors == 0 && checked > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            checked = checked + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    // one classic cycle; request held until ack is sampled
    task wb(input [5:0] ad, input w, input [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge sys_clk);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= {26'h0, ad};
            dat <= d;
            do begin
                @(posedge sys_clk);
                n = n + 1;
            end while (ack !== 1'b1 && n < 50);
            if (n >= 50) begin
                n_errors = n_errors + 1;
                end_sim;
            end
            rdo = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask
    task svc(input [7:0] c, input [7:0] at, input tg, input [31:0] d);
        begin
            wb(6'h04, 1'b1, d);
            wb(6'h00, 1'b1, {15'h0, tg, at, c});
            wb(6'h08, 1'b0, 32'h0);
            rsp = rdo;
            wb(6'h0c, 1'b0, 32'h0);
            rd = rdo;
        end
    endtask
    task ckr(input [7:0] e);
        chk({23'h0, rsp[8:0]}, {23'h0, e, 1'b1});
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        chk({24'h0, dataType}, {24'h0, `DT_INT});
        for (i = 0; i < 13; i = i + 1) begin
            a = ATL[8*i +: 8];
            svc(`SVC_GET, a, 1'b0, 32'h0);
            ckr(`ERR_NONE);
            chk(rd, dflt(a));
            if (a != `ATT_DTYPE && a != `ATT_UNITS && a != `ATT_SSTATE && a != `ATT_SVALUE) begin
                svc(`SVC_SET, a, 1'b0, 32'h5a5a);
                ckr(`ERR_RDONLY);
                svc(`SVC_GET, a, 1'b0, 32'h0);
                chk(rd, dflt(a));
            end
        end
        svc(8'h33, `ATT_UNITS, 1'b0, 32'h0);
        ckr(`ERR_NO_SVC);
        svc(`SVC_GET, 8'h02, 1'b0, 32'h0);
        ckr(`ERR_NO_ATTR);
        wb(6'h3c, 1'b0, 32'h0);
        chk(rdo, 32'h0);
        v = $random(seed);
        svc(`SVC_SET, `ATT_SVALUE, 1'b0, v);
        svc(`SVC_SET, `ATT_SSTATE, 1'b0, 32'h4);
        ckr(`ERR_BAD_VALUE);
        svc(`SVC_SET, `ATT_SSTATE, 1'b0, {30'h0, `SAFE_HOLD});
        objState <= `OST_EXEC;
        t = $random(seed);
        t = sx(t[15:0]);
        raw <= t[15:0];
        svc(`SVC_SET, `ATT_DTYPE, 1'b0, {24'h0, `DT_REAL});
        ckr(`ERR_STATE);
        svc(`SVC_GET, `ATT_VALUE, 1'b0, 32'h0);
        chk(rd, t);
        objState <= `OST_IDLE;
        raw <= raw ^ 16'h0ff0;
        for (i = 3; i >= 0; i = i - 1) begin
            // order hold, value, zero, full so hold still shows the live reading
            svc(`SVC_SET, `ATT_SSTATE, 1'b0, {30'h0, i[1:0] ^ 2'h1});
            ckr(`ERR_NONE);
            chk(valueOut, sexp(i[1:0] ^ 2'h1));
        end
        svc(`SVC_SET, `ATT_DTYPE, 1'b0, 32'h55);
        ckr(`ERR_BAD_VALUE);
        svc(`SVC_SET, `ATT_DTYPE, 1'b0, {24'h0, `DT_REAL});
        chk({24'h0, dataType}, {24'h0, `DT_REAL});
        svc(`SVC_GET, `ATT_FSCALE, 1'b0, 32'h0);
        chk(rd, `REAL_MAX);
        svc(`SVC_GET, `ATT_UNDER, 1'b0, 32'h0);
        chk(rd, `REAL_MIN);
        svc(`SVC_SET, `ATT_SVALUE, 1'b0, 32'h7f800000);
        svc(`SVC_SET, `ATT_SSTATE, 1'b0, {30'h0, `SAFE_VALUE});
        wb(6'h18, 1'b0, 32'h0);
        chk(rdo[9:2], 8'h03);
        svc(`SVC_SET, `ATT_SVALUE, 1'b0, 32'hff800000);
        svc(`SVC_GET, `ATT_STEXT, 1'b0, 32'h0);
        chk(rd, 32'h5);
        svc(`SVC_SET, `ATT_DTYPE, 1'b0, {24'h0, `DT_INT});
        wb(6'h10, 1'b1, {16'h0, `DT_REAL, 8'h01});
        chk({24'h0, dataType}, {24'h0, `DT_REAL});
        svc(`SVC_SET, `ATT_DTYPE, 1'b0, {24'h0, `DT_INT});
        ckr(`ERR_STATE);
        wb(6'h10, 1'b1, {16'h0, `DT_INT, 8'h01});
        wb(6'h14, 1'b0, 32'h0);
        chk({11'h0, rdo[23:8], rdo[7], rdo[3:0]}, {11'h0, `ADD_CONN_PATH, `ERR_BAD_VALUE, 5'h11});
        chk({24'h0, dataType}, {24'h0, `DT_REAL});
        wb(6'h10, 1'b1, 32'h2);
        svc(`SVC_SET, `ATT_DTYPE, 1'b0, {24'h0, `DT_INT});
        ckr(`ERR_NONE);
        objState <= `OST_EXEC;
        for (i = 0; i < 8; i = i + 1) begin
            t = $random(seed);
            raw <= t[31:16];
            // first two follow the pump-down procedure: absent, then explicit zero
            t = (i < 2) ? 32'h0 : sx(t[15:0]);
            svc(`SVC_ZERO, 8'h0, i != 0, (i == 0) ? 32'h1234 : t);
            ckr(`ERR_NONE);
            chk(zTgt, t);
            chk(valueOut, t);
        end
        end_sim;
    end
endmodule
